// ### logic/refclk_defines.svh
`ifndef REFCLK_DEFINES_SVH
`define REFCLK_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// sizes
`define NUM_REFS          4
`define REF_IDX_W         2
`define PRIO_W            2
`define HDIV_W            5
`define PREDIV_RATIO_W    20
`define DIV_MIN_RATIO     2

////////////////////////////////////////////////////////////////////////////////
// register bus
`define AXI_ADDR_W        8
`define AXI_DATA_W        32
`define AXI_STRB_W        4
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2

////////////////////////////////////////////////////////////////////////////////
// word map: byte address bits [7:2]; a group holds one word per input
`define WORD_W            6
`define PAD_CFG_GRP       4'h0
`define PREDIV_CFG_GRP    4'h1
`define SEL_STATUS_WORD   6'h08

////////////////////////////////////////////////////////////////////////////////
// clock_input_pad_config
`define PAD_CFG_RESET     32'h0000_8001
`define PAD_CFG_MASK      32'h0000_ffff
`define PAD_HOLD_N_BIT    15
`define PAD_HDIV_MSB      14
`define PAD_HDIV_LSB      10
`define PAD_BIAS_BIT      4
`define PAD_EN_BIT        3
`define PAD_SEL_MSB       2
`define PAD_SEL_LSB       1
`define PAD_SEL_NEG       2'h2
`define HDIV_BYPASS_MAX   5'h01

////////////////////////////////////////////////////////////////////////////////
// reference_predivider_config
`define PREDIV_CFG_RESET  32'h0050_0000
`define PREDIV_CFG_MASK   32'h035f_ffff
`define PREDIV_PRIO_MSB   25
`define PREDIV_PRIO_LSB   24
`define PREDIV_HOLD_N_BIT 22
`define PREDIV_BYPASS_BIT 20
`define PREDIV_RATIO_MSB  19
`define PREDIV_RATIO_LSB  0

////////////////////////////////////////////////////////////////////////////////
// selection status word
`define STS_USABLE_MSB    3
`define STS_USABLE_LSB    0
`define STS_SEL_MSB       5
`define STS_SEL_LSB       4
`define STS_VALID_BIT     8

`endif

// ### logic/refclk_pkg.sv
`include "refclk_defines.svh"
`default_nettype none
package refclk_pkg;

  typedef struct packed {
    logic                   awvalid;
    logic [`AXI_ADDR_W-1:0] awaddr;
    logic                   wvalid;
    logic [`AXI_DATA_W-1:0] wdata;
    logic [`AXI_STRB_W-1:0] wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`AXI_ADDR_W-1:0] araddr;
    logic                   rready;
  } axil_req_s;

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [`AXI_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
  } axil_rsp_s;

endpackage : refclk_pkg
`default_nettype wire

// ### logic/clock_div_stage.sv
`include "refclk_defines.svh"
`default_nettype none
module clock_div_stage #(
  parameter int unsigned RATIO_W = `HDIV_W
) (
  // clock, reset, enable
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  // divider control
  input  wire logic [RATIO_W-1:0] ratio,
  input  wire logic               bypass,
  input  wire logic               hold_n,
  // clock path
  input  wire logic               in_level,
  output wire logic               out_level
);

  logic               prev_reg, prev_next;
  logic               out_reg, out_next;
  logic [RATIO_W-1:0] cnt_reg, cnt_next;
  logic [RATIO_W-1:0] eff;

  // ratios below the minimum are clamped rather than left undefined
  assign eff       = (ratio < RATIO_W'(`DIV_MIN_RATIO)) ? RATIO_W'(`DIV_MIN_RATIO) : ratio;
  assign out_level = out_reg;

  always_comb begin
    prev_next = prev_reg;
    out_next  = out_reg;
    cnt_next  = cnt_reg;
    if (ce) begin
      prev_next = in_level;
      if (bypass) begin
        out_next = in_level;
        cnt_next = '0;
      end else if (!hold_n) begin
        out_next = 1'b1;
        cnt_next = '0;
      end else if (in_level && !prev_reg) begin
        // a lowered ratio must not leave the count past the new end and run the long way round
        cnt_next = (cnt_reg >= eff - RATIO_W'(1)) ? '0 : cnt_reg + RATIO_W'(1);
        out_next = (cnt_next < (eff >> 1));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // matches the set level of an upstream stage, so release gives no false edge
      prev_reg <= 1'b1;
      out_reg  <= 1'b1;
      cnt_reg  <= '0;
    end else begin
      prev_reg <= prev_next;
      out_reg  <= out_next;
      cnt_reg  <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_div_wrap;
    ce && !bypass && hold_n && in_level && !prev_reg && cnt_reg == eff - RATIO_W'(1) |=> out_reg && cnt_reg == '0;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not restart its period");

  property p_hold_set;
    ce && !bypass && !hold_n |=> out_reg && cnt_reg == '0;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("held divider not in set state");

  property p_hold_stop;
    (ce && !bypass && !hold_n) [*3] |-> $stable(out_reg);
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("held divider output still moves");

  property p_bypass;
    // sampled reset keeps the release edge, where the output still shows its reset level, out of the check
    aresetn && ce && bypass |=> out_reg == $past(in_level);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed divider not transparent");

endmodule // clock_div_stage
`default_nettype wire

// ### logic/ref_clock_input_divider_config.sv
// Behaviour
// - high-frequency divider: 2..31 divides, 0 passes
// - cleared hold bit parks high-frequency divider set (the code still passes the pad level while settings 0 and 1 bypass it)
// - pad usable only while pad enable set
// - two-bit select picks differential or single-ended pin
// - two-bit priority, zero is first choice
// - equal priority prefers lowest-numbered input
// - cleared hold bit parks pre-divider in set (the code still passes its input while the bypass bit is set)
// - bypass passes reference, else divide by ratio
//
// The register addresses and register access over AXI4-Lite were decided locally.
`include "refclk_defines.svh"
`default_nettype none
module ref_clock_input_divider_config (
  // clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // register bus
  input  wire refclk_pkg::axil_req_s axil_req,
  output wire refclk_pkg::axil_rsp_s axil_rsp,
  // reference pads and qualification
  input  wire logic [`NUM_REFS-1:0]  ref_p,
  input  wire logic [`NUM_REFS-1:0]  ref_n,
  input  wire logic [`NUM_REFS-1:0]  ref_valid,
  // pad controls
  output wire logic [`NUM_REFS-1:0]  pad_enable,
  output wire logic [`NUM_REFS-1:0]  pad_bias_on,
  // divided clocks
  output wire logic [`NUM_REFS-1:0]  hf_divided_clock,
  output wire logic [`NUM_REFS-1:0]  ref_divided_clock,
  // reference choice
  output wire logic [`REF_IDX_W-1:0] selected_ref,
  output wire logic                  selected_valid
);
  import refclk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic [`AXI_DATA_W-1:0] pad_cfg_reg     [`NUM_REFS];
  logic [`AXI_DATA_W-1:0] pad_cfg_next    [`NUM_REFS];
  logic [`AXI_DATA_W-1:0] prediv_cfg_reg  [`NUM_REFS];
  logic [`AXI_DATA_W-1:0] prediv_cfg_next [`NUM_REFS];
  axil_rsp_s              rsp_reg, rsp_next;
  logic                   aw_held_reg, aw_held_next;
  logic                   w_held_reg, w_held_next;
  logic [`AXI_ADDR_W-1:0] waddr_reg, waddr_next;
  logic [`AXI_DATA_W-1:0] wdata_reg, wdata_next;
  logic [`AXI_STRB_W-1:0] wstrb_reg, wstrb_next;
  logic [`WORD_W-1:0]     wword, rword;
  logic [`REF_IDX_W-1:0]  widx, ridx;
  logic [`REF_IDX_W-1:0]  sel_ref_reg, sel_ref_next;
  logic                   sel_valid_reg, sel_valid_next;
  logic [`PRIO_W-1:0]     best_prio;
  logic [`NUM_REFS-1:0]   usable;
  logic [`NUM_REFS-1:0]   pad_level;
  logic [`NUM_REFS-1:0]   hf_bypass;

  assign axil_rsp       = rsp_reg;
  assign selected_ref   = sel_ref_reg;
  assign selected_valid = sel_valid_reg;
  assign wword          = waddr_reg[`AXI_ADDR_W-1:2];
  assign rword          = axil_req.araddr[`AXI_ADDR_W-1:2];
  assign widx           = wword[`REF_IDX_W-1:0];
  assign ridx           = rword[`REF_IDX_W-1:0];

  function automatic logic [`AXI_DATA_W-1:0] merge_word(
    input logic [`AXI_DATA_W-1:0] old_word,
    input logic [`AXI_DATA_W-1:0] new_word,
    input logic [`AXI_STRB_W-1:0] strb,
    input logic [`AXI_DATA_W-1:0] mask
  );
    logic [`AXI_DATA_W-1:0] res;
    res = old_word;
    for (int b = 0; b < `AXI_STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: address and data may come in either order; one write and one read in flight
  always_comb begin
    rsp_next        = rsp_reg;
    aw_held_next    = aw_held_reg;
    w_held_next     = w_held_reg;
    waddr_next      = waddr_reg;
    wdata_next      = wdata_reg;
    wstrb_next      = wstrb_reg;
    pad_cfg_next    = pad_cfg_reg;
    prediv_cfg_next = prediv_cfg_reg;
    if (ce) begin
      if (axil_req.awvalid && rsp_reg.awready) begin
        aw_held_next = 1'b1;
        waddr_next   = axil_req.awaddr;
      end
      if (axil_req.wvalid && rsp_reg.wready) begin
        w_held_next = 1'b1;
        wdata_next  = axil_req.wdata;
        wstrb_next  = axil_req.wstrb;
      end
      if (rsp_reg.bvalid && axil_req.bready) begin
        rsp_next.bvalid = 1'b0;
      end
      if (aw_held_reg && w_held_reg && !rsp_reg.bvalid) begin
        aw_held_next    = 1'b0;
        w_held_next     = 1'b0;
        rsp_next.bvalid = 1'b1;
        rsp_next.bresp  = `AXI_RESP_OKAY;
        // the masks keep reserved bits at zero whatever is written
        if (wword[`WORD_W-1:`REF_IDX_W] == `PAD_CFG_GRP) begin
          pad_cfg_next[widx] = merge_word(pad_cfg_reg[widx], wdata_reg, wstrb_reg, `PAD_CFG_MASK);
        end else if (wword[`WORD_W-1:`REF_IDX_W] == `PREDIV_CFG_GRP) begin
          prediv_cfg_next[widx] = merge_word(prediv_cfg_reg[widx], wdata_reg, wstrb_reg,
                                             `PREDIV_CFG_MASK);
        end else if (wword != `SEL_STATUS_WORD) begin
          rsp_next.bresp = `AXI_RESP_SLVERR;
        end
      end
      rsp_next.awready = !aw_held_next && !rsp_next.bvalid;
      rsp_next.wready  = !w_held_next && !rsp_next.bvalid;

      if (rsp_reg.rvalid && axil_req.rready) begin
        rsp_next.rvalid = 1'b0;
      end
      if (axil_req.arvalid && rsp_reg.arready) begin
        rsp_next.rvalid = 1'b1;
        rsp_next.rresp  = `AXI_RESP_OKAY;
        rsp_next.rdata  = '0;
        if (rword[`WORD_W-1:`REF_IDX_W] == `PAD_CFG_GRP) begin
          rsp_next.rdata = pad_cfg_reg[ridx];
        end else if (rword[`WORD_W-1:`REF_IDX_W] == `PREDIV_CFG_GRP) begin
          rsp_next.rdata = prediv_cfg_reg[ridx];
        end else if (rword == `SEL_STATUS_WORD) begin
          rsp_next.rdata[`STS_USABLE_MSB:`STS_USABLE_LSB] = usable;
          rsp_next.rdata[`STS_SEL_MSB:`STS_SEL_LSB]       = sel_ref_reg;
          rsp_next.rdata[`STS_VALID_BIT]                  = sel_valid_reg;
        end else begin
          rsp_next.rresp = `AXI_RESP_SLVERR;
        end
      end
      rsp_next.arready = !rsp_next.rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_reg     <= '0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      for (int i = 0; i < `NUM_REFS; i++) begin
        pad_cfg_reg[i]    <= `PAD_CFG_RESET;
        prediv_cfg_reg[i] <= `PREDIV_CFG_RESET;
      end
    end else begin
      rsp_reg        <= rsp_next;
      aw_held_reg    <= aw_held_next;
      w_held_reg     <= w_held_next;
      waddr_reg      <= waddr_next;
      wdata_reg      <= wdata_next;
      wstrb_reg      <= wstrb_next;
      pad_cfg_reg    <= pad_cfg_next;
      prediv_cfg_reg <= prediv_cfg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference choice among usable inputs
  always_comb begin
    sel_ref_next   = sel_ref_reg;
    sel_valid_next = sel_valid_reg;
    best_prio      = '1;
    if (ce) begin
      sel_ref_next   = '0;
      sel_valid_next = 1'b0;
      for (int i = 0; i < `NUM_REFS; i++) begin
        // strict compare while scanning upward keeps the lower input on a tie
        if (usable[i] && (!sel_valid_next ||
            prediv_cfg_reg[i][`PREDIV_PRIO_MSB:`PREDIV_PRIO_LSB] < best_prio)) begin
          sel_valid_next = 1'b1;
          sel_ref_next   = `REF_IDX_W'(i);
          best_prio      = prediv_cfg_reg[i][`PREDIV_PRIO_MSB:`PREDIV_PRIO_LSB];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_ref_reg   <= '0;
      sel_valid_reg <= 1'b0;
    end else begin
      sel_ref_reg   <= sel_ref_next;
      sel_valid_reg <= sel_valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-input pad and two divider stages
  for (genvar g = 0; g < `NUM_REFS; g++) begin : g_ref
    assign pad_enable[g]  = pad_cfg_reg[g][`PAD_EN_BIT];
    assign pad_bias_on[g] = pad_cfg_reg[g][`PAD_BIAS_BIT];
    // differential, positive and dual modes all feed the positive leg into this path
    assign pad_level[g]   = pad_cfg_reg[g][`PAD_EN_BIT] &
                            ((pad_cfg_reg[g][`PAD_SEL_MSB:`PAD_SEL_LSB] == `PAD_SEL_NEG) ?
                             ref_n[g] : ref_p[g]);
    assign usable[g]      = pad_cfg_reg[g][`PAD_EN_BIT] & ref_valid[g];
    // setting 1 is reserved and treated like 0
    assign hf_bypass[g]   = pad_cfg_reg[g][`PAD_HDIV_MSB:`PAD_HDIV_LSB] <= `HDIV_BYPASS_MAX;

    clock_div_stage #(.RATIO_W(`HDIV_W)) u_hf_div (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .ratio     (pad_cfg_reg[g][`PAD_HDIV_MSB:`PAD_HDIV_LSB]),
      .bypass    (hf_bypass[g]),
      .hold_n    (pad_cfg_reg[g][`PAD_HOLD_N_BIT]),
      .in_level  (pad_level[g]),
      .out_level (hf_divided_clock[g])
    );

    clock_div_stage #(.RATIO_W(`PREDIV_RATIO_W)) u_pre_div (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .ratio     (prediv_cfg_reg[g][`PREDIV_RATIO_MSB:`PREDIV_RATIO_LSB]),
      .bypass    (prediv_cfg_reg[g][`PREDIV_BYPASS_BIT]),
      .hold_n    (prediv_cfg_reg[g][`PREDIV_HOLD_N_BIT]),
      .in_level  (hf_divided_clock[g]),
      .out_level (ref_divided_clock[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pad_off;
    (ce && aresetn && !pad_enable[0] && hf_bypass[0]) [*2] |-> !hf_divided_clock[0];
  endproperty
  a_pad_off: assert property (p_pad_off) else $error("disabled pad still supplies a clock");

  property p_pad_neg;
    ce && pad_enable[0] && hf_bypass[0] &&
      pad_cfg_reg[0][`PAD_SEL_MSB:`PAD_SEL_LSB] == `PAD_SEL_NEG |=> hf_divided_clock[0] == $past(ref_n[0]);
  endproperty
  a_pad_neg: assert property (p_pad_neg) else $error("negative pin not selected");

  property p_prio_order;
    ce && usable == 4'h3 && prediv_cfg_reg[0][`PREDIV_PRIO_MSB:`PREDIV_PRIO_LSB] >
      prediv_cfg_reg[1][`PREDIV_PRIO_MSB:`PREDIV_PRIO_LSB] |=> sel_valid_reg && sel_ref_reg == 2'h1;
  endproperty
  a_prio_order: assert property (p_prio_order) else $error("higher priority input not chosen");

  property p_none_usable;
    ce && usable == '0 |=> !sel_valid_reg;
  endproperty
  a_none_usable: assert property (p_none_usable) else $error("choice made with no usable input");

  property p_tie_low;
    ce && usable[0] && prediv_cfg_reg[0][`PREDIV_PRIO_MSB:`PREDIV_PRIO_LSB] == '0 |=>
      sel_valid_reg && sel_ref_reg == '0;
  endproperty
  a_tie_low: assert property (p_tie_low) else $error("tie not resolved to lowest input");

  property p_reserved_zero;
    (prediv_cfg_reg[0] & ~`PREDIV_CFG_MASK) == '0 && (pad_cfg_reg[0] & ~`PAD_CFG_MASK) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits hold a one");

endmodule // ref_clock_input_divider_config
`default_nettype wire

// ### verification/ref_clock_source.sv
`default_nettype none
module ref_clock_source #(
  parameter int unsigned HALF_P = 4,
  parameter int unsigned HALF_N = 6
) (
  // sampling clock
  input  wire logic       aclk,
  // pad levels toward the block
  output wire logic [3:0] ref_p,
  output wire logic [3:0] ref_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0]  p_lvl = 4'h0;
  logic [3:0]  n_lvl = 4'h0;
  int unsigned cnt_p = 0;
  int unsigned cnt_n = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // free-running oscillators: a real source never stops between uses
  // the negative pin runs at its own rate so a wrong pin choice shows as a wrong period
  always @(posedge aclk) begin
    cnt_p <= (cnt_p == HALF_P - 1) ? 0 : cnt_p + 1;
    cnt_n <= (cnt_n == HALF_N - 1) ? 0 : cnt_n + 1;
    if (cnt_p == HALF_P - 1) begin
      p_lvl <= ~p_lvl;
    end
    if (cnt_n == HALF_N - 1) begin
      n_lvl <= ~n_lvl;
    end
  end

  assign ref_p = p_lvl;
  assign ref_n = n_lvl;
endmodule // ref_clock_source
`default_nettype wire

// ### verification/ref_clock_input_divider_config_tb.sv
`include "refclk_defines.svh"
`default_nettype none
module ref_clock_input_divider_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import refclk_pkg::*;

  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  logic        ce        = 1'b1;
  axil_req_s   req       = '0;
  axil_rsp_s   rsp;
  logic [3:0]  ref_p;
  logic [3:0]  ref_n;
  logic [3:0]  ref_valid = 4'h0;
  logic [3:0]  pad_enable;
  logic [3:0]  pad_bias_on;
  logic [3:0]  hf_clk;
  logic [3:0]  ref_clk;
  logic [1:0]  selected_ref;
  logic        selected_valid;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          divs [5] = '{0, 1, 2, 5, 31};
  int          sel_per [4] = '{8, 8, 12, 8};
  int          prio [4] = '{3, 2, 1, 1};

  always #2.5 aclk = ~aclk;

  ref_clock_source i_src (.aclk(aclk), .ref_p(ref_p), .ref_n(ref_n));

  ref_clock_input_divider_config i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .axil_req(req), .axil_rsp(rsp),
    .ref_p(ref_p), .ref_n(ref_n), .ref_valid(ref_valid),
    .pad_enable(pad_enable), .pad_bias_on(pad_bias_on),
    .hf_divided_clock(hf_clk), .ref_divided_clock(ref_clk),
    .selected_ref(selected_ref), .selected_valid(selected_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // address and data offered together, each released once taken; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw;
    bit w;
    bit b;
    n = 0;
    aw = 0;
    w = 0;
    b = 0;
    r = 2'h3;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    while (!b && n < 200) begin
      @(posedge aclk);
      n++;
      if (!aw && rsp.awready) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid === 1'b1) begin
        b = 1;
        r = rsp.bresp;
      end
    end
    req.bready <= 1'b0;
    // one idle edge, so a following call never re-drives ready in the same step
    @(posedge aclk);
    chk("write answered", 32'h1, {31'h0, b});
  endtask

  task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ar;
    bit got;
    n = 0;
    ar = 0;
    got = 0;
    d = '0;
    r = 2'h3;
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    while (!got && n < 200) begin
      @(posedge aclk);
      n++;
      if (!ar && rsp.arready) begin
        ar = 1;
        req.arvalid <= 1'b0;
      end
      if (rsp.rvalid === 1'b1) begin
        got = 1;
        d = rsp.rdata;
        r = rsp.rresp;
      end
    end
    req.rready <= 1'b0;
    @(posedge aclk);
    chk("read answered", 32'h1, {31'h0, got});
  endtask

  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk("write resp", 32'(`AXI_RESP_OKAY), 32'(rs));
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    rdt(a, rd, rs);
    chk("read resp", 32'(`AXI_RESP_OKAY), 32'(rs));
    chk(name, exp, rd);
  endtask

  // first rise may straddle a setting change, so time the second to the third; 0 means stopped
  task automatic chk_per(input bit pre, input int idx, input int exp, input string name);
    int t;
    int r;
    int p;
    logic v;
    logic last;
    t = 0;
    r = 0;
    p = 0;
    last = 1'b1;
    while (r < 3 && t < 1000) begin
      @(posedge aclk);
      t++;
      v = pre ? ref_clk[idx] : hf_clk[idx];
      if (v === 1'b1 && last === 1'b0) begin
        r++;
        if (r == 2) p = -t;
        if (r == 3) p += t;
      end
      last = v;
    end
    if (r < 3) p = 0;
    chk(name, 32'(exp), 32'(p));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    $display("[ERR] run time expected done seen hung");
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_rd(8'h00, 32'h0000_8001, "pad0 reset");
    chk_rd(8'h10, 32'h0050_0000, "prediv0 reset");
    chk_rd(8'h20, 32'h0000_0000, "status reset");
    cfg(8'h04, 32'hffff_ffff);
    chk_rd(8'h04, 32'h0000_ffff, "pad1 mask");
    chk("pad1 enable", 32'h1, {31'h0, pad_enable[1]});
    chk("pad1 bias", 32'h1, {31'h0, pad_bias_on[1]});
    cfg(8'h14, 32'hffff_ffff);
    chk_rd(8'h14, 32'h035f_ffff, "prediv1 mask");
    cfg(8'h04, 32'h0000_0000);
    chk("pad1 off", 32'h0, {30'h0, pad_enable[1], pad_bias_on[1]});
    cfg(8'h14, 32'h0050_0000);
    wr(8'h40, 32'h1234_5678, rs);
    chk("unmapped write", 32'(`AXI_RESP_SLVERR), 32'(rs));
    rdt(8'h40, rd, rs);
    chk("unmapped read", 32'(`AXI_RESP_SLVERR), 32'(rs));
    chk("unmapped data", 32'h0, rd);
    foreach (divs[i]) begin
      cfg(8'h00, 32'h0000_8008 | (32'(divs[i]) << 10));
      chk_per(0, 0, 8 * ((divs[i] < 2) ? 1 : divs[i]), "hf period");
    end
    cfg(8'h00, 32'h0000_1008);
    chk_per(0, 0, 0, "hf held");
    chk("hf held level", 32'h1, {31'h0, hf_clk[0]});
    cfg(8'h00, 32'h0000_0008);
    chk_per(0, 0, 8, "hf held bypass");
    foreach (sel_per[i]) begin
      cfg(8'h00, 32'h0000_8008 | (32'(i) << 1));
      chk_per(0, 0, sel_per[i], "pad select");
    end
    cfg(8'h00, 32'h0000_8000);
    chk_per(0, 0, 0, "pad disabled");
    cfg(8'h00, 32'h0000_8008);
    chk_per(1, 0, 8, "prediv bypass");
    // ratios of 2 or more, divided rate stays below 33 MHz
    cfg(8'h10, 32'h0000_0003);
    chk_per(1, 0, 0, "prediv held");
    chk("prediv held level", 32'h1, {31'h0, ref_clk[0]});
    cfg(8'h10, 32'h0040_0003);
    chk_per(1, 0, 24, "prediv by 3");
    cfg(8'h10, 32'h0000_0002);
    cfg(8'h10, 32'h0040_0002);
    chk_per(1, 0, 16, "prediv by 2");
    cfg(8'h10, 32'h0010_0000);
    chk_per(1, 0, 8, "prediv held bypass");
    ref_valid <= 4'hf;
    for (int i = 0; i < 4; i++) begin
      cfg(8'(4 * i), 32'h0000_8008);
    end
    repeat (3) @(posedge aclk);
    chk("tie choice", 32'h4, {29'h0, selected_valid, selected_ref});
    foreach (prio[i]) begin
      cfg(8'(8'h10 + 4 * i), 32'h0050_0000 | (32'(prio[i]) << 24));
    end
    repeat (3) @(posedge aclk);
    chk("prio choice", 32'h6, {29'h0, selected_valid, selected_ref});
    chk_rd(8'h20, 32'h0000_012f, "status word");
    ref_valid <= 4'hb;
    cfg(8'h0c, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk("usable choice", 32'h5, {29'h0, selected_valid, selected_ref});
    ref_valid <= 4'h0;
    repeat (3) @(posedge aclk);
    chk("none usable", 32'h0, {31'h0, selected_valid});
    // enable low freezes the dividers, high lets them run again
    ce <= 1'b0;
    chk_per(0, 0, 0, "frozen divider");
    ce <= 1'b1;
    chk_per(0, 0, 8, "resumed divider");
    give_verdict();
  end
endmodule // ref_clock_input_divider_config_tb
`default_nettype wire
